// >>> core/scd_decoder.sv
// Serial op-code decoder: label table, divider, control word and FIFO access.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: After select falls, eight op-code bits arrive MSB first on rising clock edges.
// R2: Write data follows the op code directly, MSB first, one bit per rising edge.
// R3: Read data MSB appears on the first falling edge after the eighth code bit.
// R4: Reset, set and start codes act after the last input bit, select still low.
// R5: Code 01 pulses full reset, emptying both data FIFOs and flags.
// R6: Code 02 clears all 256 label-match entries after the eighth bit.
// R7: Code 03 sets all label-match entries after the eighth bit.
// R8: Codes 04/05 clear/set the one entry addressed by an 8-bit field.
// R9: Code 06 writes 256 entries from address FF downward, one bit each.
// R10: Code 07 loads the divide value, used when clock source select is set.
// R11: Only divide codes x1, x2, x4, x8, xA give a clock; others none.
// R12: Host picks timing clock and divide so the divided rate is 1 MHz.
// R13: Code 08 returns and removes one receive word, zeros when empty.
// R14: Code 09 streams receive words back to back, zeros after the last.
// R15: Code 0A returns 8-bit status, code 0B the 16-bit control word.
// R16: Code 0C returns the divide value last written by code 07.
// R17: Code 0D shifts out all 256 label entries from FF downward.
// R18: Code 0E writes up to 32 words into the transmit path.
// R19: Code 10 loads its 16-bit field into the control register.
// R20: Code 11 empties the transmit FIFO after the eighth bit.
// R21: Code 12 starts transmission only while control bit 13 is zero.
// R22: Undefined codes change nothing and drive only zeros on the output.
module scd_decoder
(
   input wire logic clk, // System clock, 100 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire scd_pkg::scd_spi_in_type spi, // Select, serial clock and serial input.
   output logic so, // Serial output data.
   output logic so_oe_n, // Serial output enable, low while driving.
   input wire logic aclk, // Timing clock, sampled as a level.
   output logic arinc_tick, // One-cycle pulse per divided timing clock period.
   input wire logic [7:0] status, // Status byte assembled outside.
   input wire logic rx_valid, // Receive FIFO holds a word.
   input wire logic [31:0] rx_data, // Oldest receive word.
   output logic rx_ready, // Pops the receive word.
   output logic tx_valid, // Buffered transmit word available.
   input wire logic tx_ready, // Transmit FIFO takes the word.
   output logic [31:0] tx_data, // Buffered transmit word.
   output logic full_reset, // Pulse: empty both FIFOs and flags.
   output logic tx_fifo_clear, // Pulse: empty the transmit FIFO.
   output logic tx_start, // Pulse: begin transmission.
   output logic [255:0] label_table, // Label-match entries.
   output scd_pkg::scd_cfg_type cfg // Control word and divide value.
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic op_is_read(input logic [7:0] op);
      op_is_read = (op == scd_pkg::OP_RX_READ_ONE) || (op == scd_pkg::OP_RX_DUMP) ||
                   (op == scd_pkg::OP_STATUS_READ) || (op == scd_pkg::OP_CTRL_READ) ||
                   (op == scd_pkg::OP_DIV_READ) || (op == scd_pkg::OP_LABEL_READ_ALL);
   endfunction

   function automatic logic op_uses_rx(input logic [7:0] op);
      op_uses_rx = (op == scd_pkg::OP_RX_READ_ONE) || (op == scd_pkg::OP_RX_DUMP);
   endfunction

   function automatic logic div_code_ok(input logic [3:0] code);
      div_code_ok = (code == scd_pkg::DIV_BY_1) || (code == scd_pkg::DIV_BY_2) ||
                    (code == scd_pkg::DIV_BY_4) || (code == scd_pkg::DIV_BY_8) ||
                    (code == scd_pkg::DIV_BY_10);
   endfunction

   // ----------------------------------------------------------------------
   // Serial edge detection
   // ----------------------------------------------------------------------
   scd_pkg::scd_state_type state;
   logic sck_q;
   logic sck_rise;
   logic sck_fall;
   logic [2:0] op_cnt;
   logic [6:0] op_sr;
   logic [7:0] op;
   logic [7:0] op_now;
   logic last_op;
   logic body_rise;
   logic [10:0] body_cnt;
   logic [31:0] in_sr;
   logic [31:0] next_in;
   logic reading;
   logic [31:0] out_sr;
   logic [4:0] out_cnt;
   logic [7:0] label_idx;
   logic [15:0] ctrl;
   logic [7:0] div_value;
   logic stream_reload;
   logic buf_in_valid;
   logic buf_in_ready;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sck_q <= 1'b0;
      end
      else
      begin
         sck_q <= spi.sck;
      end
   end

   assign sck_rise = spi.sck & ~sck_q & ~spi.cs_n;
   assign sck_fall = ~spi.sck & sck_q & ~spi.cs_n;
   assign op_now = {op_sr, spi.si};
   assign last_op = sck_rise && (state != scd_pkg::ST_BODY) && (op_cnt == scd_pkg::OPCODE_LAST_BIT); // [R1]
   assign body_rise = sck_rise && (state == scd_pkg::ST_BODY);
   assign next_in = {in_sr[30:0], spi.si};

   // ----------------------------------------------------------------------
   // Frame state and op-code capture
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= scd_pkg::ST_IDLE;
         op_cnt <= '0;
         op_sr <= '0;
         op <= scd_pkg::OP_NONE_A;
      end
      else if (spi.cs_n)
      begin
         state <= scd_pkg::ST_IDLE;
         op_cnt <= '0;
      end
      else
      begin
         case (state)
            scd_pkg::ST_IDLE,
            scd_pkg::ST_OPCODE:
            begin
               if (sck_rise)
               begin
                  op_sr <= op_now[6:0]; // [R1]
                  op_cnt <= op_cnt + 3'h1;
               end
               if (last_op)
               begin
                  op <= op_now;
                  state <= scd_pkg::ST_BODY;
               end
               else
               begin
                  state <= scd_pkg::ST_OPCODE;
               end
            end
            scd_pkg::ST_BODY:
            begin
               state <= scd_pkg::ST_BODY;
            end
            default:
            begin
               state <= scd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Data field capture
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         body_cnt <= '0;
         in_sr <= '0;
      end
      else if (last_op)
      begin
         body_cnt <= '0;
      end
      else if (body_rise)
      begin
         in_sr <= next_in; // [R2]
         if (body_cnt != scd_pkg::BODY_COUNT_MAX)
         begin
            body_cnt <= body_cnt + 11'h001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Label-match table
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         label_table <= scd_pkg::LABEL_RESET;
      end
      else if (last_op && (op_now == scd_pkg::OP_LABEL_CLEAR_ALL))
      begin
         label_table <= '0; // [R4] [R6]
      end
      else if (last_op && (op_now == scd_pkg::OP_LABEL_SET_ALL))
      begin
         label_table <= '1; // [R4] [R7]
      end
      else if (body_rise && (body_cnt == scd_pkg::BYTE_LAST_BIT) &&
               ((op == scd_pkg::OP_LABEL_CLEAR_ONE) || (op == scd_pkg::OP_LABEL_SET_ONE)))
      begin
         label_table[next_in[7:0]] <= (op == scd_pkg::OP_LABEL_SET_ONE); // [R8]
      end
      else if (body_rise && (op == scd_pkg::OP_LABEL_WRITE_ALL) && (body_cnt < 11'(scd_pkg::LABEL_COUNT)))
      begin
         label_table[label_idx] <= spi.si; // [R9]
      end
   end

   // Walks downward from the top address for both the bulk write and the bulk read.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         label_idx <= scd_pkg::LABEL_TOP;
      end
      else if (last_op)
      begin
         label_idx <= scd_pkg::LABEL_TOP; // [R9] [R17]
      end
      else if ((body_rise && (op == scd_pkg::OP_LABEL_WRITE_ALL)) ||
               (sck_fall && reading && (op == scd_pkg::OP_LABEL_READ_ALL)))
      begin
         label_idx <= label_idx - 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Control word and divide value
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= scd_pkg::CTRL_RESET;
         div_value <= scd_pkg::DIV_RESET;
      end
      else if (body_rise)
      begin
         if ((op == scd_pkg::OP_CTRL_WRITE) && (body_cnt == scd_pkg::CTRL_LAST_BIT))
         begin
            ctrl <= next_in[15:0]; // [R19]
         end
         if ((op == scd_pkg::OP_DIV_WRITE) && (body_cnt == scd_pkg::BYTE_LAST_BIT))
         begin
            div_value <= next_in[7:0]; // [R10]
         end
      end
   end

   assign cfg.ctrl = ctrl;
   assign cfg.div_value = div_value;

   // ----------------------------------------------------------------------
   // Command pulses
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         full_reset <= 1'b0;
         tx_fifo_clear <= 1'b0;
         tx_start <= 1'b0;
      end
      else
      begin
         full_reset <= last_op && (op_now == scd_pkg::OP_FULL_RESET); // [R4] [R5]
         tx_fifo_clear <= last_op && (op_now == scd_pkg::OP_TX_CLEAR); // [R20]
         tx_start <= last_op && (op_now == scd_pkg::OP_TX_START) &&
                     !ctrl[scd_pkg::CTRL_TX_MODE_BIT]; // [R21]
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // A dump reloads on the last bit of each word so words follow with no gap.
   assign stream_reload = sck_fall && reading && (op == scd_pkg::OP_RX_DUMP) &&
                          (out_cnt == scd_pkg::WORD_LAST_BIT); // [R14]
   assign rx_ready = rx_valid && ((last_op && op_uses_rx(op_now)) || stream_reload); // [R13]

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reading <= 1'b0;
         out_sr <= '0;
         out_cnt <= '0;
         so <= 1'b0;
      end
      else if (spi.cs_n)
      begin
         reading <= 1'b0;
         so <= 1'b0;
      end
      else if (last_op)
      begin
         reading <= op_is_read(op_now); // [R22]
         out_cnt <= '0;
         case (op_now)
            scd_pkg::OP_RX_READ_ONE,
            scd_pkg::OP_RX_DUMP:
            begin
               out_sr <= rx_valid ? rx_data : '0; // [R13]
            end
            scd_pkg::OP_STATUS_READ:
            begin
               out_sr <= {status, 24'h000000}; // [R15]
            end
            scd_pkg::OP_CTRL_READ:
            begin
               out_sr <= {ctrl, 16'h0000}; // [R15]
            end
            scd_pkg::OP_DIV_READ:
            begin
               out_sr <= {div_value, 24'h000000}; // [R16]
            end
            default:
            begin
               out_sr <= '0;
            end
         endcase
      end
      else if (sck_fall)
      begin
         if (!reading)
         begin
            so <= 1'b0; // [R22]
         end
         else if (op == scd_pkg::OP_LABEL_READ_ALL)
         begin
            so <= label_table[label_idx]; // [R17]
         end
         else
         begin
            so <= out_sr[31]; // [R3]
            out_cnt <= out_cnt + 5'h01;
            if (stream_reload)
            begin
               out_sr <= rx_valid ? rx_data : '0; // [R14]
            end
            else
            begin
               out_sr <= {out_sr[30:0], 1'b0};
            end
         end
      end
   end

   assign so_oe_n = spi.cs_n;

   // ----------------------------------------------------------------------
   // Transmit word buffer
   // ----------------------------------------------------------------------
   // Words arriving while the buffer is full are dropped: the serial master cannot be stalled.
   assign buf_in_valid = body_rise && (op == scd_pkg::OP_TX_WRITE) &&
                         (body_cnt[4:0] == scd_pkg::WORD_LAST_BIT) && !body_cnt[10]; // [R18]

   scd_fifo #(
      .WIDTH(scd_pkg::BUF_WIDTH),
      .DEPTH(scd_pkg::BUF_DEPTH)
   ) tx_buffer (
      .clk(clk),
      .reset_n(reset_n),
      .flush(full_reset | tx_fifo_clear), // [R5] [R20]
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(next_in),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   // ----------------------------------------------------------------------
   // Timing clock divider
   // ----------------------------------------------------------------------
   logic aclk_q;
   logic aclk_rise;
   logic [3:0] div_cnt;

   assign aclk_rise = aclk & ~aclk_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aclk_q <= 1'b0;
         div_cnt <= '0;
         arinc_tick <= 1'b0;
      end
      else
      begin
         aclk_q <= aclk;
         if (!ctrl[scd_pkg::CTRL_CLK_SRC_BIT])
         begin
            arinc_tick <= aclk_rise;
            div_cnt <= '0;
         end
         else if (!div_code_ok(div_value[3:0]))
         begin
            arinc_tick <= 1'b0; // [R11]
            div_cnt <= '0;
         end
         else if (aclk_rise)
         begin
            if (div_cnt >= div_value[3:0] - 4'h1)
            begin
               arinc_tick <= 1'b1; // [R10]
               div_cnt <= '0;
            end
            else
            begin
               arinc_tick <= 1'b0;
               div_cnt <= div_cnt + 4'h1;
            end
         end
         else
         begin
            arinc_tick <= 1'b0;
         end
      end
   end

endmodule // scd_decoder

`default_nettype wire

// >>> core/scd_pkg.sv
// Shared constants, op codes, states and carrier types of the serial command decoder.
package scd_pkg;

   // ----------------------------------------------------------------------
   // Op codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] OP_NONE_A = 8'h00;
   localparam logic [7:0] OP_FULL_RESET = 8'h01;
   localparam logic [7:0] OP_LABEL_CLEAR_ALL = 8'h02;
   localparam logic [7:0] OP_LABEL_SET_ALL = 8'h03;
   localparam logic [7:0] OP_LABEL_CLEAR_ONE = 8'h04;
   localparam logic [7:0] OP_LABEL_SET_ONE = 8'h05;
   localparam logic [7:0] OP_LABEL_WRITE_ALL = 8'h06;
   localparam logic [7:0] OP_DIV_WRITE = 8'h07;
   localparam logic [7:0] OP_RX_READ_ONE = 8'h08;
   localparam logic [7:0] OP_RX_DUMP = 8'h09;
   localparam logic [7:0] OP_STATUS_READ = 8'h0a;
   localparam logic [7:0] OP_CTRL_READ = 8'h0b;
   localparam logic [7:0] OP_DIV_READ = 8'h0c;
   localparam logic [7:0] OP_LABEL_READ_ALL = 8'h0d;
   localparam logic [7:0] OP_TX_WRITE = 8'h0e;
   localparam logic [7:0] OP_NONE_B = 8'h0f;
   localparam logic [7:0] OP_CTRL_WRITE = 8'h10;
   localparam logic [7:0] OP_TX_CLEAR = 8'h11;
   localparam logic [7:0] OP_TX_START = 8'h12;

   // ----------------------------------------------------------------------
   // Field lengths and positions
   // ----------------------------------------------------------------------
   localparam logic [2:0] OPCODE_LAST_BIT = 3'h7;
   localparam int WORD_BITS = 32;
   localparam int CTRL_BITS = 16;
   localparam int LABEL_COUNT = 256;
   localparam logic [7:0] LABEL_TOP = 8'hff;
   localparam logic [10:0] BYTE_LAST_BIT = 11'h007;
   localparam logic [10:0] CTRL_LAST_BIT = 11'h00f;
   localparam logic [4:0] WORD_LAST_BIT = 5'h1f;
   localparam logic [10:0] BODY_COUNT_MAX = 11'h7ff;
   localparam int CTRL_CLK_SRC_BIT = 1;
   localparam int CTRL_TX_MODE_BIT = 13;
   localparam int BUF_WIDTH = 32;
   localparam int BUF_DEPTH = 8;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [7:0] DIV_RESET = 8'h01;
   localparam logic [255:0] LABEL_RESET = 256'h0;

   // Accepted divide codes, low nibble only.
   localparam logic [3:0] DIV_BY_1 = 4'h1;
   localparam logic [3:0] DIV_BY_2 = 4'h2;
   localparam logic [3:0] DIV_BY_4 = 4'h4;
   localparam logic [3:0] DIV_BY_8 = 4'h8;
   localparam logic [3:0] DIV_BY_10 = 4'ha;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_OPCODE = 3'b010,
      ST_BODY = 3'b100
   } scd_state_type;

   typedef struct packed
   {
      logic cs_n;
      logic sck;
      logic si;
   } scd_spi_in_type;

   typedef struct packed
   {
      logic [15:0] ctrl;
      logic [7:0] div_value;
   } scd_cfg_type;

endpackage

// >>> core/scd_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and a synchronous flush.
`timescale 1ns/100ps
`default_nettype none

module scd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   input wire logic clk, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic flush, // Empties the FIFO.
   input wire logic in_valid, // Word offered.
   output logic in_ready, // Room for a word.
   input wire logic [WIDTH-1:0] in_data, // Word written.
   output logic out_valid, // Word available.
   input wire logic out_ready, // Drain side takes the word.
   output logic [WIDTH-1:0] out_data // Oldest word.
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_idx];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_idx] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + AW'(1);
         end
         if (pop)
         begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + AW'(1);
         end
         if (push && !pop)
         begin
            count <= count + (AW+1)'(1);
         end
         else if (pop && !push)
         begin
            count <= count - (AW+1)'(1);
         end
      end
   end

endmodule // scd_fifo

`default_nettype wire

// >>> tb/scd_decoder_props.sv
// Port-level assertions of the serial command decoder.
`timescale 1ns/100ps
`default_nettype none

module scd_decoder_props
(
   input wire logic clk, // Clock.
   input wire logic reset_n, // Reset, active low.
   input wire scd_pkg::scd_spi_in_type spi, // Serial pins.
   input wire logic so, // Serial out.
   input wire logic so_oe_n, // Out enable.
   input wire logic rx_valid, // Rx word present.
   input wire logic rx_ready, // Rx pop.
   input wire logic full_reset, // Reset pulse.
   input wire logic tx_fifo_clear, // Clear pulse.
   input wire logic tx_start, // Start pulse.
   input wire logic [255:0] label_table, // Labels.
   input wire scd_pkg::scd_cfg_type cfg // Config.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_oe_follows_cs: assert property (so_oe_n == spi.cs_n)
      else $error("so_oe_n differs from cs_n");
   a_so_idle_low: assert property (spi.cs_n |=> !so)
      else $error("so high after deselect");
   a_reset_one_cycle: assert property (full_reset |=> !full_reset)
      else $error("full_reset longer than one cycle");
   a_clear_one_cycle: assert property (tx_fifo_clear |=> !tx_fifo_clear)
      else $error("tx_fifo_clear longer than one cycle");
   a_start_mode_gate: assert property (tx_start |-> !cfg.ctrl[scd_pkg::CTRL_TX_MODE_BIT] && !$past(tx_start))
      else $error("tx_start in wrong mode or too long");
   a_pulse_in_frame: assert property ((full_reset || tx_fifo_clear || tx_start) |-> !$past(spi.cs_n))
      else $error("pulse outside a frame");
   a_label_in_frame: assert property (!$stable(label_table) |-> !$past(spi.cs_n))
      else $error("label table changed outside a frame");
   a_cfg_in_frame: assert property (!$stable(cfg) |-> !$past(spi.cs_n))
      else $error("cfg changed outside a frame");
   a_pop_one_word: assert property (rx_ready |-> rx_valid ##1 !rx_ready)
      else $error("rx pop while empty or longer than one cycle");
   c_full_reset: cover property (full_reset);
   c_tx_start: cover property (tx_start);
   c_rx_pop: cover property (rx_ready);
endmodule // scd_decoder_props

bind scd_decoder scd_decoder_props u_props (.clk(clk), .reset_n(reset_n), .spi(spi), .so(so), .so_oe_n(so_oe_n),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .full_reset(full_reset), .tx_fifo_clear(tx_fifo_clear),
   .tx_start(tx_start), .label_table(label_table), .cfg(cfg));
`default_nettype wire

// >>> tb/scd_host.sv
// Behavioural serial host that frames op codes and data toward the decoder.
`timescale 1ns/100ps
`default_nettype none

module scd_host
(
   input wire logic clk, // Clock.
   input wire logic so, // Decoder serial out.
   output scd_pkg::scd_spi_in_type spi // Select, clock, data.
);
   // Idle pins rest where their pulls leave them: deselected, clock and data low.
   initial spi = 3'b100;

   task automatic xfer(input logic [7:0] op, input int n, input logic [255:0] wd, output logic [255:0] rd);
      rd = '0;
      @(posedge clk);
      #1 spi.cs_n = 1'b0;
      for (int i = 0; i < n + 8; i++)
      begin
         @(posedge clk);
         #1 spi.si = (i < 8) ? op[7 - i] : wd[n + 7 - i];
         repeat (4) @(posedge clk);
         #1 spi.sck = 1'b1;
         rd = {rd[254:0], so};
         repeat (4) @(posedge clk);
         #1 spi.sck = 1'b0;
      end
      repeat (4) @(posedge clk);
      #1 spi = 3'b100;
      repeat (3) @(posedge clk);
   endtask
endmodule // scd_host
`default_nettype wire

// >>> tb/spi_opcode_command_decoder_test.sv
// Self-checking bench of the serial command decoder.
`timescale 1ns/100ps
`default_nettype none

module spi_opcode_command_decoder_test;
   localparam logic [255:0] LBL = {8{32'hb00d1e55}};
   logic clk, reset_n, aclk, rx_valid, rx_ready, tx_valid, tx_ready, so, so_oe_n, arinc_tick;
   logic full_reset, tx_fifo_clear, tx_start;
   logic [7:0] status;
   logic [31:0] rx_data, tx_data;
   logic [255:0] label_table, rd, wd;
   scd_pkg::scd_spi_in_type spi;
   scd_pkg::scd_cfg_type cfg;
   logic [31:0] rxq[$], txq[$];
   logic [7:0] dv[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h1a, 8'h13};
   int nt[6] = '{32, 16, 8, 4, 3, 0};
   logic [7:0] cl[2] = '{8'h11, 8'h01};
   logic [7:0] un[3] = '{8'h00, 8'h0f, 8'h13};
   int n_mismatch = 0, checked = 0, n_tick = 0, n_start = 0, n_reset = 0;

   scd_host u_host (.clk(clk), .so(so), .spi(spi));
   scd_decoder u_dut (.clk(clk), .reset_n(reset_n), .spi(spi), .so(so), .so_oe_n(so_oe_n), .aclk(aclk),
      .arinc_tick(arinc_tick), .status(status), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .full_reset(full_reset),
      .tx_fifo_clear(tx_fifo_clear), .tx_start(tx_start), .label_table(label_table), .cfg(cfg));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Timing clock at a tenth of the system clock, so divide code 1a gives 1 MHz.
   always
   begin
      repeat (5) @(posedge clk);
      #1 aclk = ~aclk;
   end

   // Receive FIFO stand-in; an empty head shows inverted data so stale words cannot pass.
   always @(posedge clk)
   begin
      if (rx_ready && rx_valid)
         void'(rxq.pop_front());
      if (tx_valid && tx_ready)
         txq.push_back(tx_data);
      n_tick += int'(arinc_tick);
      n_start += int'(tx_start);
      n_reset += int'(full_reset);
      #1 rx_valid = rxq.size() > 0;
      rx_data = rx_valid ? rxq[0] : ~rx_data;
   end

   task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic op(input logic [7:0] c, input int n, input logic [255:0] d);
      u_host.xfer(c, n, d, rd);
   endtask

   task automatic end_sim();
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #400000;
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      reset_n = 1'b0;
      aclk = 1'b0;
      status = 8'ha5;
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data = 32'h0;
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
      op(8'h0c, 8, '0);
      chk("div reset", 8'h01, rd);
      #2 n_tick = 0;
      repeat (320) @(posedge clk);
      chk("tick direct", 1, (n_tick >= 31) && (n_tick <= 33));
      op(8'h10, 16, 16'h2002);
      op(8'h0b, 16, '0);
      chk("ctrl read", 16'h2002, rd);
      op(8'h12, 0, '0);
      chk("start gated", 0, n_start);
      op(8'h10, 16, 16'h0002);
      op(8'h12, 0, '0);
      chk("start", 1, n_start);
      for (int k = 0; k < 6; k++)
      begin
         op(8'h07, 8, dv[k]);
         op(8'h0c, 8, '0);
         chk("div read", dv[k], rd);
         #2 n_tick = 0;
         repeat (320) @(posedge clk);
         chk("tick count", 1, (n_tick >= nt[k] - 1) && (n_tick <= nt[k] + 1));
      end
      op(8'h03, 0, '0);
      chk("set all", {256{1'b1}}, label_table);
      op(8'h04, 8, 8'h35);
      chk("clear one", ~(256'h1 << 8'h35), label_table);
      op(8'h02, 0, '0);
      op(8'h05, 8, 8'hff);
      chk("set one", 256'h1 << 8'hff, label_table);
      op(8'h06, 256, LBL);
      chk("label write", LBL, label_table);
      op(8'h0d, 256, '0);
      chk("label read", LBL, rd);
      op(8'h0a, 8, '0);
      chk("status", 8'ha5, rd);
      rxq = '{32'h8badf00d, 32'h1234abcd};
      op(8'h08, 32, '0);
      chk("rx read", 32'h8badf00d, rd);
      op(8'h09, 64, '0);
      chk("rx dump", {32'h1234abcd, 32'h0}, rd);
      op(8'h08, 32, '0);
      chk("rx empty", 0, rd);
      for (int k = 0; k < 8; k++)
         wd[255 - 32 * k -: 32] = 32'hc0de0000 + k;
      op(8'h0e, 256, wd);
      op(8'h0e, 32, 32'hdeadbeef);
      #1 tx_ready = 1'b1;
      repeat (12) @(posedge clk);
      chk("tx count", 8, txq.size());
      chk("tx order", {32'hc0de0000, 32'hc0de0007}, {txq[0], txq[7]});
      #1 tx_ready = 1'b0;
      foreach (cl[k])
      begin
         op(8'h0e, 32, 32'h5a5a0000);
         chk("tx held", 1, tx_valid);
         op(cl[k], 0, '0);
         chk("tx flushed", 0, tx_valid);
      end
      chk("reset pulses", 1, n_reset);
      foreach (un[k])
      begin
         op(un[k], 16, 16'hffff);
         chk("undefined out", 0, rd);
         chk("undefined state", {LBL, 16'h0002, 8'h13}, {label_table, cfg});
      end
      end_sim();
   end
endmodule // spi_opcode_command_decoder_test
`default_nettype wire
